// *** sad_pkg.sv ***
// Purpose: Shared constants and types for the SMM and I/O address decoder
// Assumes: 32-bit host addresses, 16-bit I/O space plus the wrap bit
// Notes: Register offsets are byte addresses of aligned 32-bit words
package sad_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;   // Window and mode enables
  localparam logic [4:0] REG_CEIL = 5'h04;   // Memory ceiling in MB
  localparam logic [4:0] REG_APERTURE_BASE_SETTING = 5'h08; // Aperture base setting
  localparam logic [4:0] REG_APMASK = 5'h0C; // Aperture size mask
  localparam logic [4:0] REG_SHADOW = 5'h10; // Shadow read/write enables
  localparam logic [4:0] REG_STATUS = 5'h14; // Abort count, last route
  localparam logic [4:0] REG_CFGPTR = 5'h18; // Configuration pointer
  // Control fields
  localparam int CB_COMPAT = 0; // Compatible window enable
  localparam int CB_OPEN = 1;   // SMM open flag
  localparam int CB_CLOSE = 2;  // SMM close flag
  localparam int CB_HIGH = 3;   // High remapped segment enable
  localparam int CB_TOP = 4;    // Top segment enable
  localparam int CB_GFX = 5;    // Internal graphics enable
  localparam int CB_BLK64 = 6;  // Completion block is 64 bytes
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h40;
  localparam logic [11:0] CEIL_RST = 12'h040;
  localparam logic [11:0] TOP_SZ_MB = 12'h001;
  localparam int MB_LSB = 20;
  localparam int SHD_LSB = 14;  // 16 KB shadow blocks
  localparam int SHD_N = 16;
  // ----------------------------------------------------------------
  // Address windows
  // ----------------------------------------------------------------
  localparam logic [31:0] COMPAT_LO = 32'h000A0000;
  localparam logic [31:0] COMPAT_HI = 32'h000BFFFF;
  localparam logic [31:0] HIGH_LO = 32'hFEDA0000;
  localparam logic [31:0] HIGH_HI = 32'hFEDBFFFF;
  localparam logic [31:0] SHD_LO = 32'h000C0000;
  localparam logic [31:0] SHD_HI = 32'h000FFFFF;
  localparam logic [15:0] IO_WRAP4 = 16'hFFFD;
  localparam logic [15:0] IO_WRAP2 = 16'hFFFF;
  localparam logic [15:0] CFG_ADDR_PORT = 16'h0CF8;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0CFC;
  localparam logic [15:0] GFX_IO_LO = 16'h03B0;
  localparam logic [15:0] GFX_IO_HI = 16'h03DF;
  localparam logic [15:0] IDE1_LO = 16'h01F0;
  localparam logic [15:0] IDE1_HI = 16'h01F7;
  localparam logic [15:0] IDE2_LO = 16'h0170;
  localparam logic [15:0] IDE2_HI = 16'h0177;
  localparam logic [2:0] LEN2 = 3'h2;
  localparam logic [2:0] LEN4 = 3'h4;
  localparam logic [8:0] BLK32 = 9'h020;
  localparam logic [8:0] BLK64 = 9'h040;
  localparam logic [8:0] HUB_MAX_LEN = 9'h100;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RT_NONE = 3'b000, RT_DRAM = 3'b001, RT_HUB = 3'b010,
    RT_GFX = 3'b011, RT_INT = 3'b100, RT_ABORT = 3'b101
  } sad_route_e;
  typedef enum logic [1:0] {
    RG_BAD = 2'b00, RG_DRAM = 2'b01, RG_APER = 2'b10, RG_VGA = 2'b11
  } sad_rgn_e;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BLK = 1'b1} sad_state_e;
endpackage : sad_pkg

// *** sad_decoder.sv ***
// Purpose: Host bridge decoder for SMM windows, shadowing and I/O space
// Assumes: One request per port per cycle; inputs synchronous to clk
// Notes: Hub requests are split into naturally aligned blocks
`timescale 1ns/1ps
module sad_decoder
  import sad_pkg::*;
#(
  parameter int HUB_AW = 40, // Hub address width
  parameter int LEN_W = 9    // Hub length width, holds 256
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_valid,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_io,
  input wire logic cpu_write,
  input wire logic cpu_wb,
  input wire logic cpu_smm,
  input wire logic cpu_data,
  input wire logic cpu_gfx_src,
  input wire logic [2:0] cpu_len,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_out_valid,
  output logic [2:0] cpu_route,
  output logic [31:0] cpu_out_addr,
  output logic cpu_addr_bit16,
  output logic cpu_nonposted,
  input wire logic hub_valid,
  output logic hub_ready,
  input wire logic [HUB_AW-1:0] hub_addr,
  input wire logic hub_io,
  input wire logic hub_write,
  input wire logic hub_need_cpl,
  input wire logic [LEN_W-1:0] hub_len,
  output logic hub_blk_valid,
  output logic [31:0] hub_blk_addr,
  output logic [LEN_W-1:0] hub_blk_bytes,
  output logic [1:0] hub_blk_tgt,
  output logic hub_blk_cpl,
  output logic hub_blk_abort,
  output logic hub_blk_ones,
  output logic hub_blk_be_off,
  output logic hub_blk_snoop,
  output logic hub_blk_last
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_r; // First stage, read only by the second
  logic rst_n;    // Released copy used everywhere
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r;   // Window enables and flags
  logic [11:0] ceil_r;         // Memory ceiling, MB units
  logic [31:0] aperture_base_setting_r;       // Aperture base setting
  logic [31:0] apmask_r;       // Aperture size setting as a mask
  logic [31:0] shadow_r;       // Low half read, high half write
  logic [31:0] cfgptr_r;       // Configuration address pointer
  logic [15:0] abort_cnt_r;    // Hub blocks ended by abort
  logic [2:0] last_route_r;    // Last CPU route
  logic wait_r;
  logic [31:0] rdata_r;
  wire bus_req = avs_read | avs_write;
  // Write lands only at the edge where waitrequest is seen low
  wire bus_wr = avs_write & ~wait_r;
  wire [31:0] status_w = {abort_cnt_r, 13'h0000, last_route_r};
  wire hit_ctrl = avs_address == REG_CTRL;
  wire hit_ceil = avs_address == REG_CEIL;
  wire hit_apb = avs_address == REG_APERTURE_BASE_SETTING;
  wire hit_apm = avs_address == REG_APMASK;
  wire hit_shd = avs_address == REG_SHADOW;
  wire hit_sts = avs_address == REG_STATUS;
  wire hit_cfg = avs_address == REG_CFGPTR;
  // Unmapped words read as zero and ignore writes
  wire [31:0] rmux =
    hit_ctrl ? {25'h0000000, ctrl_r} :
    hit_ceil ? {20'h00000, ceil_r} :
    hit_apb ? aperture_base_setting_r :
    hit_apm ? apmask_r :
    hit_shd ? shadow_r :
    hit_sts ? status_w :
    hit_cfg ? cfgptr_r : 32'h00000000;

  // One wait cycle per access, then a one-cycle answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else if (clk_en) begin
      wait_r <= ~(bus_req & wait_r);
      if (bus_req & wait_r) begin
        rdata_r <= rmux;
      end
    end
  end

  // Software settings; with open and close both set, open wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      ceil_r <= CEIL_RST;
      aperture_base_setting_r <= 32'h00000000;
      apmask_r <= 32'h00000000;
      shadow_r <= 32'h00000000;
    end else if (clk_en & bus_wr) begin
      if (hit_ctrl) ctrl_r <= avs_writedata[CTRL_W-1:0];
      if (hit_ceil) ceil_r <= avs_writedata[11:0];
      if (hit_apb) aperture_base_setting_r <= avs_writedata;
      if (hit_apm) apmask_r <= avs_writedata;
      if (hit_shd) shadow_r <= avs_writedata;
    end
  end
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // Shared memory map, used for host, graphics and hub sources
  // ----------------------------------------------------------------
  wire [11:0] top_mb = ceil_r - TOP_SZ_MB;
  function automatic logic in_compat(input logic [31:0] a);
    in_compat = (a >= COMPAT_LO) && (a <= COMPAT_HI);
  endfunction : in_compat
  function automatic logic in_top(input logic [31:0] a);
    in_top = ctrl_r[CB_TOP] && (a[31:MB_LSB] == top_mb);
  endfunction : in_top
  function automatic logic below_ceil(input logic [31:0] a);
    below_ceil = a[31:MB_LSB] < ceil_r;
  endfunction : below_ceil
  // Region of a hub address; SMM space is never a valid target
  function automatic sad_rgn_e rgn_of(input logic [31:0] a,
                                      input logic wr);
    if (in_compat(a)) begin
      rgn_of = wr ? RG_VGA : RG_BAD;
    end else if (in_top(a)) begin
      rgn_of = RG_BAD;
    end else if (below_ceil(a)) begin
      rgn_of = RG_DRAM;
    end else if ((apmask_r != 32'h00000000) &&
                 ((a & apmask_r) == (aperture_base_setting_r & apmask_r))) begin
      rgn_of = RG_APER;
    end else begin
      rgn_of = RG_BAD;
    end
  endfunction : rgn_of

  // ----------------------------------------------------------------
  // CPU and graphics source decode
  // ----------------------------------------------------------------
  wire [15:0] io_a = cpu_addr[15:0];
  // Graphics-sourced cycles use the same map but are never in SMM
  wire smm_mode = cpu_smm & ~cpu_gfx_src;
  // Open admits everyone; close steers SMM data to the bus
  wire compat_ok = ctrl_r[CB_OPEN] |
                   (smm_mode & ~(ctrl_r[CB_CLOSE] & cpu_data));
  // Write-backs keep cache coherency even outside SMM
  wire ext_ok = smm_mode | cpu_wb;
  wire hit_high = ctrl_r[CB_HIGH] && (cpu_addr >= HIGH_LO) &&
                  (cpu_addr <= HIGH_HI);
  wire hit_cmp = ctrl_r[CB_COMPAT] && in_compat(cpu_addr);
  wire hit_top = in_top(cpu_addr);
  wire hit_shd_w = (cpu_addr >= SHD_LO) && (cpu_addr <= SHD_HI);
  wire [3:0] shd_idx = cpu_addr[SHD_LSB+3:SHD_LSB];
  wire shd_dram = cpu_write ? shadow_r[SHD_N + 32'(shd_idx)]
                            : shadow_r[shd_idx];
  wire gfx_on = ctrl_r[CB_GFX];
  // Four bytes from FFFDh..FFFFh or two from FFFFh wrap past 64K
  wire wrap16 = ((cpu_len == LEN4) && (io_a >= IO_WRAP4)) ||
                ((cpu_len == LEN2) && (io_a == IO_WRAP2));
  wire io_cfga = io_a == CFG_ADDR_PORT;
  wire io_cfgd = io_a[15:2] == CFG_DATA_PORT[15:2];
  wire io_gfx = gfx_on && (io_a >= GFX_IO_LO) && (io_a <= GFX_IO_HI);
  wire io_ide = ((io_a >= IDE1_LO) && (io_a <= IDE1_HI)) ||
                ((io_a >= IDE2_LO) && (io_a <= IDE2_HI));
  sad_route_e io_rt;
  sad_route_e mem_rt;
  logic [31:0] mem_a;
  // I/O route: configuration ports first, then graphics, then hub
  assign io_rt = (io_cfga | io_cfgd) ? RT_INT :
                 io_gfx ? RT_GFX :
                 RT_HUB;
  // Memory route by window priority
  assign mem_rt =
    hit_high ? (ext_ok ? RT_DRAM : RT_ABORT) :
    hit_cmp ? (compat_ok ? RT_DRAM : (gfx_on ? RT_GFX : RT_HUB)) :
    hit_top ? (ext_ok ? RT_DRAM : RT_ABORT) :
    hit_shd_w ? (shd_dram ? RT_DRAM : RT_HUB) :
    below_ceil(cpu_addr) ? RT_DRAM : RT_HUB;
  // High segment lands on the compatible DRAM range
  assign mem_a = hit_high ? {12'h000, cpu_addr[MB_LSB-1:0]}
                          : cpu_addr;
  wire [2:0] rt_w = cpu_io ? io_rt : mem_rt;
  // I/O address goes out as is, wrap flag beside it
  wire [31:0] out_a_w = cpu_io ? {16'h0000, io_a} : mem_a;
  wire np_w = cpu_io & cpu_write & io_ide & (io_rt == RT_HUB);

  logic cpu_out_valid_r;
  logic [2:0] cpu_route_r;
  logic [31:0] cpu_out_addr_r;
  logic cpu_a16_r;
  logic cpu_np_r;
  // Registered CPU answer, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_out_valid_r <= 1'b0;
      cpu_route_r <= RT_NONE;
      cpu_out_addr_r <= 32'h00000000;
      cpu_a16_r <= 1'b0;
      cpu_np_r <= 1'b0;
      last_route_r <= RT_NONE;
    end else if (clk_en) begin
      cpu_out_valid_r <= cpu_valid;
      if (cpu_valid) begin
        cpu_route_r <= rt_w;
        cpu_out_addr_r <= out_a_w;
        cpu_a16_r <= cpu_io & wrap16;
        cpu_np_r <= np_w;
        last_route_r <= rt_w;
      end
    end
  end

  // Configuration pointer captured from a dword write to its port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgptr_r <= 32'h00000000;
    end else if (clk_en && cpu_valid && cpu_io && cpu_write &&
                 io_cfga && (cpu_len == LEN4)) begin
      cfgptr_r <= cpu_wdata;
    end
  end
  assign cpu_out_valid = cpu_out_valid_r;
  assign cpu_route = cpu_route_r;
  assign cpu_out_addr = cpu_out_addr_r;
  assign cpu_addr_bit16 = cpu_a16_r;
  assign cpu_nonposted = cpu_np_r;

  // ----------------------------------------------------------------
  // Hub request splitter
  // ----------------------------------------------------------------
  sad_state_e st_r;
  logic ready_r;
  logic [31:0] cur_r;         // Start of the next block
  logic [LEN_W-1:0] rem_r;    // Bytes still to cover
  logic wr_r;
  logic cpl_r;
  logic start_ok_r;
  logic [1:0] start_rgn_r;
  logic bv_r, bcpl_r, babt_r, bones_r, bbe_r, bsnp_r, blast_r;
  logic [31:0] baddr_r;
  logic [LEN_W-1:0] bbytes_r;
  logic [1:0] btgt_r;
  wire take = hub_valid & ready_r;
  wire hub_hi = hub_addr[HUB_AW-1:32] != '0;
  sad_rgn_e acc_rgn;
  sad_rgn_e cur_rgn;
  assign acc_rgn = rgn_of(hub_addr[31:0], hub_write);
  assign cur_rgn = rgn_of(cur_r, wr_r);
  wire [LEN_W-1:0] bsz = ctrl_r[CB_BLK64] ? BLK64 : BLK32;
  wire [LEN_W-1:0] off = cur_r[LEN_W-1:0] & (bsz - 1'b1);
  wire [LEN_W-1:0] room = bsz - off;
  // Never let a block cross a natural block edge
  wire [LEN_W-1:0] step = (rem_r < room) ? rem_r : room;
  // Block is good only if the start was good and stays on its device
  wire blk_ok = start_ok_r && (cur_rgn == start_rgn_r);
  wire need_st = ~wr_r | cpl_r;
  wire is_last = rem_r == step;

  // Accept, then walk block by block; I/O and high cycles end at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      ready_r <= 1'b1;
      cur_r <= 32'h00000000;
      rem_r <= '0;
      wr_r <= 1'b0;
      cpl_r <= 1'b0;
      start_ok_r <= 1'b0;
      start_rgn_r <= RG_BAD;
    end else if (clk_en) begin
      case (st_r)
        ST_IDLE: begin
          if (take && !hub_io && !hub_hi) begin
            st_r <= ST_BLK;
            ready_r <= 1'b0;
            cur_r <= hub_addr[31:0];
            // Zero length is taken as one byte
            rem_r <= (hub_len == '0) ? LEN_W'(1) :
                     (hub_len > HUB_MAX_LEN) ? HUB_MAX_LEN : hub_len;
            wr_r <= hub_write;
            cpl_r <= hub_need_cpl;
            start_ok_r <= acc_rgn != RG_BAD;
            start_rgn_r <= acc_rgn;
          end
        end
        ST_BLK: begin
          cur_r <= cur_r + 32'(step);
          rem_r <= rem_r - step;
          if (is_last) begin
            st_r <= ST_IDLE;
            ready_r <= 1'b1;
          end
        end
        default: begin
          st_r <= ST_IDLE;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  // Block results; invalid split blocks go to address zero, snooped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {bv_r, bcpl_r, babt_r, bones_r, bbe_r, bsnp_r, blast_r} <= '0;
      baddr_r <= 32'h00000000;
      bbytes_r <= '0;
      btgt_r <= RG_BAD;
      abort_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      bv_r <= 1'b0;
      if (st_r == ST_IDLE && take && (hub_io || hub_hi)) begin
        // I/O refused; high reads aborted; high writes dropped
        bv_r <= hub_io | ~hub_write;
        bcpl_r <= 1'b1;
        babt_r <= 1'b1;
        bones_r <= ~hub_write;
        bbe_r <= 1'b0;
        bsnp_r <= 1'b0;
        blast_r <= 1'b1;
        baddr_r <= hub_addr[31:0];
        bbytes_r <= hub_len;
        btgt_r <= RG_BAD;
        if (hub_io | ~hub_write) abort_cnt_r <= abort_cnt_r + 16'h0001;
      end else if (st_r == ST_BLK) begin
        bv_r <= 1'b1;
        bcpl_r <= need_st;
        babt_r <= ~blk_ok & need_st;
        bones_r <= ~blk_ok & ~wr_r;
        bbe_r <= ~blk_ok & wr_r;
        bsnp_r <= 1'b1;
        blast_r <= is_last;
        baddr_r <= blk_ok ? cur_r : 32'h00000000;
        bbytes_r <= step;
        btgt_r <= blk_ok ? cur_rgn : RG_BAD;
        if (~blk_ok & need_st) abort_cnt_r <= abort_cnt_r + 16'h0001;
      end
    end
  end
  assign hub_ready = ready_r;
  assign hub_blk_valid = bv_r;
  assign hub_blk_addr = baddr_r;
  assign hub_blk_bytes = bbytes_r;
  assign hub_blk_tgt = btgt_r;
  assign hub_blk_cpl = bcpl_r;
  assign hub_blk_abort = babt_r;
  assign hub_blk_ones = bones_r;
  assign hub_blk_be_off = bbe_r;
  assign hub_blk_snoop = bsnp_r;
  assign hub_blk_last = blast_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);
  sequence s_hub_take;
    hub_valid && ready_r && st_r == ST_IDLE;
  endsequence
  sequence s_mem_req;
    cpu_valid && !cpu_io;
  endsequence
  a_high_remap: assert property (s_mem_req ##0 hit_high && ext_ok
    |=> cpu_route == RT_DRAM && cpu_out_addr[31:MB_LSB] == 12'h000 &&
        cpu_out_addr[MB_LSB-1:0] == $past(cpu_addr[MB_LSB-1:0]))
    else $error("high segment not remapped");
  a_compat_same: assert property (s_mem_req ##0 hit_cmp && !hit_high &&
    compat_ok |=> cpu_route == RT_DRAM && cpu_out_addr == $past(cpu_addr))
    else $error("compatible window translated");
  a_top_nonsmm: assert property (s_mem_req ##0 hit_top && !hit_high &&
    !hit_cmp && !smm_mode && !cpu_wb |=> cpu_route == RT_ABORT)
    else $error("top segment open to non-SMM access");
  a_io_wrap: assert property (cpu_valid && cpu_io && cpu_len == LEN4 &&
    io_a >= IO_WRAP4 |=> cpu_addr_bit16 && cpu_out_addr[15:0] ==
    $past(io_a)) else $error("I/O wrap bit missing");
  a_cfg_claim: assert property (cpu_valid && cpu_io && io_cfga
    |=> cpu_route == RT_INT) else $error("config port not claimed");
  a_ide_np: assert property (cpu_valid && cpu_io && cpu_write && io_ide
    |=> cpu_nonposted) else $error("IDE write posted");
  a_hub_io_abort: assert property (s_hub_take ##0 hub_io
    |=> hub_blk_valid && hub_blk_abort && hub_blk_cpl && hub_ready)
    else $error("hub I/O not aborted");
  a_hub_hi_drop: assert property (s_hub_take ##0 !hub_io && hub_hi &&
    hub_write |=> !hub_blk_valid) else $error("high hub write not dropped");
  a_blk_zero: assert property (hub_blk_valid && hub_blk_snoop &&
    hub_blk_tgt == RG_BAD |-> hub_blk_addr == 32'h00000000 &&
    (hub_blk_ones || hub_blk_be_off)) else $error("invalid block not zeroed");
  a_blk_bound: assert property (hub_blk_valid && hub_blk_snoop
    |-> hub_blk_bytes <= BLK64 && hub_blk_bytes != '0)
    else $error("block exceeds natural size");
  a_hub_walk: assert property (s_hub_take ##0 !hub_io && !hub_hi &&
    hub_len <= BLK32 |=> ##[1:2] hub_blk_valid && hub_blk_last)
    else $error("short hub request not finished");
endmodule : sad_decoder

// *** sad_hub_model.sv ***
// Purpose: Hub-side requester standing in for the downstream hub port
// Assumes: send is entered just after a rising edge of clk
// Notes: On release hub_addr shows the inverted address; flags and length keep their last values
`timescale 1ns/1ps
module sad_hub_model (
  input wire logic clk,
  input wire logic hub_ready,
  output logic hub_valid,
  output logic [39:0] hub_addr,
  output logic hub_io,
  output logic hub_write,
  output logic hub_need_cpl,
  output logic [8:0] hub_len
);
  initial begin
    hub_valid = 1'b0;
    hub_addr = '0;
    {hub_io, hub_write, hub_need_cpl} = 3'h0;
    hub_len = 9'h001;
  end
  // Hold the request until the take edge, then let go of it
  task automatic send(input logic [39:0] a, input logic [2:0] f,
      input logic [8:0] n);
    hub_valid <= 1'b1;
    hub_addr <= a;
    {hub_io, hub_write, hub_need_cpl} <= f;
    hub_len <= n;
    @(posedge clk);
    while (hub_ready !== 1'b1) @(posedge clk);
    hub_valid <= 1'b0;
    hub_addr <= ~a;
  endtask : send
endmodule : sad_hub_model

// *** smm_io_hub_address_decoder_tb_top.sv ***
// Purpose: Self-checking bench for the SMM and I/O address decoder
// Assumes: Ceiling stays at its 64 MB reset value; 32 byte blocks at the end
// Notes: Outputs are sampled at the edge after they were updated
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module smm_io_hub_address_decoder_tb_top;
  import sad_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, nb;
  logic [31:0] seed = 32'h27, rd, wd, a;
  int failures = 0, checks_done = 0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = '0, avs_readdata, cpu_addr = '0;
  logic cpu_valid = 1'b0, cpu_wb, cpu_write, cpu_io, cpu_smm;
  logic cpu_data = 1'b1, cpu_gfx = 1'b0;
  logic [2:0] cpu_len = '0, cpu_route;
  logic [31:0] cpu_wdata = '0, cpu_out_addr, hub_blk_addr;
  logic cpu_out_valid, cpu_addr_bit16, cpu_nonposted, hub_valid, hub_ready;
  logic hub_io, hub_write, hub_need_cpl, hub_blk_valid, hub_blk_cpl;
  logic [39:0] hub_addr;
  logic [8:0] hub_len, hub_blk_bytes;
  logic [1:0] hub_blk_tgt;
  logic hub_blk_abort, hub_blk_ones, hub_blk_be_off, hub_blk_snoop;
  logic hub_blk_last;
  initial {cpu_wb, cpu_write, cpu_io, cpu_smm} = 4'h0;
  always #5 clk = ~clk;
  // Clock enable tied high: the bench never freezes the block
  sad_decoder u_sad_decoder (.clk, .resetn, .clk_en(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .cpu_valid, .cpu_addr, .cpu_io, .cpu_write, .cpu_wb, .cpu_smm,
    .cpu_data, .cpu_gfx_src(cpu_gfx), .cpu_len, .cpu_wdata,
    .cpu_out_valid, .cpu_route, .cpu_out_addr, .cpu_addr_bit16,
    .cpu_nonposted, .hub_valid, .hub_ready, .hub_addr, .hub_io, .hub_write,
    .hub_need_cpl, .hub_len, .hub_blk_valid, .hub_blk_addr, .hub_blk_bytes,
    .hub_blk_tgt, .hub_blk_cpl, .hub_blk_abort, .hub_blk_ones,
    .hub_blk_be_off, .hub_blk_snoop, .hub_blk_last);
  sad_hub_model u_sad_hub_model (.clk, .hub_ready, .hub_valid, .hub_addr,
    .hub_io, .hub_write, .hub_need_cpl, .hub_len);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected wrap flag for an I/O access of n bytes at a
  function automatic logic wrap(input logic [15:0] a, input logic [2:0] n);
    return (n == LEN4 && a >= IO_WRAP4) || (n == LEN2 && a == IO_WRAP2);
  endfunction : wrap
  // Expected target address: the high segment lands on A0000h-BFFFFh
  function automatic logic [31:0] xaddr(input logic [31:0] ad);
    return (ad >= HIGH_LO && ad <= HIGH_HI) ? {12'h000, ad[19:0]} : ad;
  endfunction : xaddr
  // Register access; one idle edge after release avoids re-entry races
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] d);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : av
  // Processor request; f = {wb, write, io, smm}, ef = {bit16, nonposted}
  task automatic cpu(input logic [31:0] ad, input logic [3:0] f,
      input logic [2:0] n, input logic [2:0] er, input logic [1:0] ef);
    wd = rnd();
    cpu_valid <= 1'b1;
    cpu_addr <= ad;
    {cpu_wb, cpu_write, cpu_io, cpu_smm} <= f;
    cpu_len <= n;
    cpu_wdata <= wd;
    @(posedge clk);
    cpu_valid <= 1'b0;
    @(posedge clk);
    `CHK("cpu_valid", 1'b1, cpu_out_valid)
    `CHK("route", er, cpu_route)
    `CHK("addr", xaddr(ad), cpu_out_addr)
    `CHK("flags", ef, {cpu_addr_bit16, cpu_nonposted})
  endtask : cpu
  // One hub block; eb of zero checks only abort, completion and last
  task automatic blk(input logic [31:0] ea, input logic [8:0] eb,
      input logic [1:0] et, input logic [3:0] ef);
    int k;
    k = 0;
    @(posedge clk);
    while (hub_blk_valid !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    `CHK("blk_valid", 1'b1, hub_blk_valid)
    if (eb == 9'h000) `CHK("blk_abort", 3'h7,
        {hub_blk_abort, hub_blk_cpl, hub_blk_last})
    else begin
      `CHK("blk_addr", ea, hub_blk_addr)
      `CHK("blk_bytes", eb, hub_blk_bytes)
      `CHK("blk_tgt", et, hub_blk_tgt)
      `CHK("blk_flags", ef,
          {hub_blk_abort, hub_blk_ones, hub_blk_be_off, hub_blk_last})
    end
    if (et == RG_BAD && eb != 9'h000) `CHK("snoop", 1'b1, hub_blk_snoop)
  endtask : blk
  task automatic complete_run();
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    av(1'b0, REG_CTRL, '0);
    `CHK("ctrl", {25'h0, CTRL_RST}, rd)
    av(1'b0, REG_CEIL, '0);
    `CHK("ceil", {20'h0, CEIL_RST}, rd)
    av(1'b1, REG_CTRL, 32'h79);
    av(1'b0, 5'h1C, '0);
    `CHK("unmapped", 32'h0, rd)
    cpu(COMPAT_LO, 4'h1, LEN4, RT_DRAM, 2'h0);
    cpu(COMPAT_HI, 4'h0, LEN4, RT_GFX, 2'h0);
    cpu(32'hFEDA1234, 4'h1, LEN4, RT_DRAM, 2'h0);
    cpu(32'h03F00010, 4'h1, LEN4, RT_DRAM, 2'h0);
    cpu(32'h03F00010, 4'h0, LEN4, RT_ABORT, 2'h0);
    cpu(32'h03F00010, 4'hC, LEN4, RT_DRAM, 2'h0);
    cpu(32'h03EFFFF0, 4'h0, LEN4, RT_DRAM, 2'h0);
    av(1'b1, REG_CTRL, 32'h7B);
    cpu(COMPAT_LO, 4'h0, LEN4, RT_DRAM, 2'h0);
    av(1'b1, REG_CTRL, 32'h7D);
    cpu(COMPAT_LO, 4'h1, LEN4, RT_GFX, 2'h0);
    cpu_data <= 1'b0;
    cpu(COMPAT_LO, 4'h1, LEN4, RT_DRAM, 2'h0);
    cpu_gfx <= 1'b1;
    cpu(COMPAT_LO, 4'h1, LEN4, RT_GFX, 2'h0);
    {cpu_data, cpu_gfx} <= 2'h2;
    av(1'b1, REG_SHADOW, 32'h00010000);
    cpu(SHD_LO, 4'h0, LEN4, RT_HUB, 2'h0);
    cpu(SHD_LO, 4'h4, LEN4, RT_DRAM, 2'h0);
    cpu({16'h0, CFG_ADDR_PORT}, 4'h6, LEN4, RT_INT, 2'h0);
    av(1'b0, REG_CFGPTR, '0);
    `CHK("cfg_ptr", wd, rd)
    cpu({16'h0, CFG_DATA_PORT}, 4'h2, LEN4, RT_INT, 2'h0);
    cpu({16'h0, GFX_IO_LO}, 4'h2, LEN2, RT_GFX, 2'h0);
    cpu({16'h0, IDE1_LO}, 4'h6, LEN2, RT_HUB, 2'h1);
    cpu({16'h0, IDE2_HI}, 4'h2, LEN2, RT_HUB, 2'h0);
    cpu({16'h0, IO_WRAP4}, 4'h2, LEN4, RT_HUB, 2'h2);
    cpu({16'h0, IO_WRAP2}, 4'h2, LEN2, RT_HUB, 2'h2);
    repeat (8) begin
      a = rnd();
      a[31:16] = a[4] ? 16'hFFF8 | a[2:0] : 16'h4000 | a[11:0];
      a[2:0] = a[5] ? LEN4 : LEN2;
      cpu({16'h0, a[31:16]}, 4'h6, a[2:0], RT_HUB,
          {wrap(a[31:16], a[2:0]), 1'b0});
    end
    u_sad_hub_model.send(40'h1010, 3'h0, 9'h040);
    blk(32'h1010, 9'h030, RG_DRAM, 4'h0);
    blk(32'h1040, 9'h010, RG_DRAM, 4'h1);
    u_sad_hub_model.send(40'h03EFFFE0, 3'h0, 9'h040);
    blk(32'h03EFFFE0, 9'h020, RG_DRAM, 4'h0);
    blk(32'h0, 9'h020, RG_BAD, 4'hD);
    u_sad_hub_model.send(40'h03F00000, 3'h3, 9'h004);
    blk(32'h0, 9'h004, RG_BAD, 4'hB);
    u_sad_hub_model.send({8'h0, COMPAT_LO}, 3'h2, 9'h004);
    blk(COMPAT_LO, 9'h004, RG_VGA, 4'h1);
    u_sad_hub_model.send({8'h0, COMPAT_LO}, 3'h0, 9'h004);
    blk(32'h0, 9'h004, RG_BAD, 4'hD);
    u_sad_hub_model.send(40'h0, 3'h0, 9'h100);
    for (int i = 0; i < 4; i++)
      blk(32'(i * 64), 9'h040, RG_DRAM, {3'h0, i == 3});
    av(1'b1, REG_CTRL, 32'h3D);
    av(1'b1, REG_APERTURE_BASE_SETTING, 32'h80000000);
    av(1'b1, REG_APMASK, 32'hF0000000);
    u_sad_hub_model.send(40'h0080000010, 3'h0, 9'h030);
    blk(32'h80000010, 9'h010, RG_APER, 4'h0);
    blk(32'h80000020, 9'h020, RG_APER, 4'h1);
    u_sad_hub_model.send(40'h0100, 3'h4, 9'h004);
    blk(32'h0, 9'h000, RG_BAD, 4'h0);
    u_sad_hub_model.send(40'h0100000000, 3'h0, 9'h004);
    blk(32'h0, 9'h000, RG_BAD, 4'h0);
    u_sad_hub_model.send(40'h0100000040, 3'h2, 9'h004);
    nb = 1'b0;
    repeat (6) begin
      @(posedge clk);
      nb |= hub_blk_valid;
    end
    `CHK("dropped", 1'b0, nb)
    av(1'b0, REG_STATUS, '0);
    `CHK("status", 32'h00050002, rd)
    complete_run();
  end
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule : smm_io_hub_address_decoder_tb_top
